// File: tpg_host.sv
// Purpose: host controller that drives a three-level pwm pin and a three-level
//          conduction mode select pin of a buck power-stage gate driver
// Assumes: pins released (oe low) sit at the driver's open/three-state level
// Notes: period below the driver's shortest legal period is stretched
`timescale 1ns/1ps
`default_nettype none
module tpg_host import tpg_pkg::*; #(
	parameter int WIDTH = PERIOD_WIDTH,
	parameter int POWERUP_CYCLES = STARTUP_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// user requests
	input wire logic enable,
	input wire logic [1:0] mode_req,
	input wire logic phase_shed,
	input wire logic [WIDTH-1:0] period_req,
	input wire logic [WIDTH-1:0] on_time_req,
	// pwm pin toward the driver
	output logic pwm_out,
	output logic pwm_oe,
	// conduction mode select pin toward the driver
	output logic conduction_mode_select_out,
	output logic conduction_mode_select_oe,
	// status
	output logic ready
);

	tpg_state_type state;
	tpg_state_type next_state;
	logic [WAIT_WIDTH-1:0] wait_count;
	logic [WAIT_WIDTH-1:0] next_wait_count;
	logic next_pwm_out;
	logic next_pwm_oe;
	logic next_mode_out;
	logic next_mode_oe;
	logic next_ready;
	logic gen_run;
	logic gen_level;
	logic [WIDTH-1:0] eff_period;
	logic [WIDTH-1:0] eff_on;
	logic want_on;

	localparam logic [WIDTH-1:0] MIN_PERIOD = WIDTH'(MIN_PERIOD_CYCLES);
	localparam logic [WAIT_WIDTH-1:0] WAIT_LAST = WAIT_WIDTH'(POWERUP_CYCLES - 1);

	// stretch period to the legal minimum
	always_comb begin
		eff_period = (period_req < MIN_PERIOD) ? MIN_PERIOD : period_req;
		eff_on = (on_time_req > eff_period) ? eff_period : on_time_req;
	end

	assign want_on = enable && (mode_req != MODE_SHUTDOWN);
	assign gen_run = (state == ST_RUN);

	tpg_pwm_gen #(
		.WIDTH(WIDTH)
	) u_gen (
		.clk(clk),
		.resetn(resetn),
		.run(gen_run),
		.period(eff_period),
		.on_time(eff_on),
		.level(gen_level)
	);

	always_comb begin
		next_state = state;
		next_wait_count = wait_count;
		case (state)
			ST_OFF: begin
				next_wait_count = '0;
				if (want_on) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// hold off switching for the restart latency
				if (!want_on) begin
					next_state = ST_OFF;
				end else if (wait_count == WAIT_LAST) begin
					next_state = phase_shed ? ST_PARK : ST_RUN;
				end else begin
					next_wait_count = wait_count + WAIT_WIDTH'(1);
				end
			end
			ST_RUN: begin
				if (!want_on) begin
					next_state = ST_OFF;
				end else if (phase_shed) begin
					next_state = ST_PARK;
				end
			end
			ST_PARK: begin
				if (!want_on) begin
					next_state = ST_OFF;
				end else if (!phase_shed) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	// pin levels follow the state being entered, so no pin lags the fsm
	always_comb begin
		// high forces conduction, low allows diode emulation
		next_mode_out = (mode_req == MODE_FORCED_CCM);
		// released pin is the driver's shutdown level
		next_mode_oe = (next_state != ST_OFF);
		// pwm stays released until the driver is known to be up
		next_pwm_oe = (next_state == ST_RUN);
		next_pwm_out = (next_state == ST_RUN) && gen_level;
		next_ready = (next_state == ST_RUN) || (next_state == ST_PARK);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_OFF;
			wait_count <= '0;
			pwm_out <= 1'b0;
			pwm_oe <= 1'b0;
			conduction_mode_select_out <= 1'b0;
			conduction_mode_select_oe <= 1'b0;
			ready <= 1'b0;
		end else begin
			state <= next_state;
			wait_count <= next_wait_count;
			pwm_out <= next_pwm_out;
			pwm_oe <= next_pwm_oe;
			conduction_mode_select_out <= next_mode_out;
			conduction_mode_select_oe <= next_mode_oe;
			ready <= next_ready;
		end
	end

	// helper counters, read only by the checks below
	logic [WAIT_WIDTH-1:0] since_mode_on;
	logic [WIDTH-1:0] since_rise;
	logic seen_rise;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			since_mode_on <= '0;
			since_rise <= '0;
			seen_rise <= 1'b0;
		end else begin
			if (!conduction_mode_select_oe) begin
				since_mode_on <= '0;
			end else if (since_mode_on != '1) begin
				since_mode_on <= since_mode_on + WAIT_WIDTH'(1);
			end
			if (!pwm_oe) begin
				seen_rise <= 1'b0;
				since_rise <= '0;
			end else if (pwm_out && !$past(pwm_out)) begin
				seen_rise <= 1'b1;
				since_rise <= WIDTH'(1);
			end else if (since_rise != '1) begin
				since_rise <= since_rise + WIDTH'(1);
			end
		end
	end

	sequence s_mode_released;
		!conduction_mode_select_oe;
	endsequence

	sequence s_pwm_starts;
		!pwm_oe ##1 pwm_oe;
	endsequence

	a_pwm_released_off: assert property (@(posedge clk) disable iff (!resetn)
		s_mode_released |-> !pwm_oe)
		else $error("pwm driven while driver is shut down");

	a_restart_latency: assert property (@(posedge clk) disable iff (!resetn)
		s_pwm_starts |-> since_mode_on >= WAIT_WIDTH'(POWERUP_CYCLES))
		else $error("pwm driven before restart latency elapsed");

	a_wake_then_run: assert property (@(posedge clk) disable iff (!resetn)
		$rose(conduction_mode_select_oe) |-> !pwm_oe [*8])
		else $error("pwm driven right after driver wake");

	a_min_period: assert property (@(posedge clk) disable iff (!resetn)
		pwm_oe && pwm_out && !$past(pwm_out) && seen_rise |-> since_rise >= MIN_PERIOD)
		else $error("pwm switching above highest allowed frequency");

	a_mode_level: assert property (@(posedge clk) disable iff (!resetn)
		conduction_mode_select_oe && $stable(mode_req) && $past(conduction_mode_select_oe)
		|-> conduction_mode_select_out == (mode_req == MODE_FORCED_CCM))
		else $error("mode select level does not match request");

	a_shutdown_release: assert property (@(posedge clk) disable iff (!resetn)
		mode_req == MODE_SHUTDOWN |=> !conduction_mode_select_oe ##0 !pwm_oe)
		else $error("shutdown request did not release pins");

endmodule
`default_nettype wire

// File: tpg_pkg.sv
// Purpose: shared constants and types of the gate-driver host controller
// Assumes: 200 MHz system clock
// Notes: times are held in their own unit and turned into cycle counts here
package tpg_pkg;

	localparam int CLK_MHZ = 200;
	// driver restart latency after leaving the open mode-select level
	localparam int STARTUP_LATENCY_NS = 15000;
	localparam int STARTUP_CYCLES = (STARTUP_LATENCY_NS * CLK_MHZ + 999) / 1000;
	// highest switching frequency the driver accepts
	localparam int MAX_SWITCH_KHZ = 1500;
	localparam int MIN_PERIOD_CYCLES = (CLK_MHZ * 1000 + MAX_SWITCH_KHZ - 1) / MAX_SWITCH_KHZ;

	localparam int WAIT_WIDTH = 12;
	localparam int PERIOD_WIDTH = 16;

	// conduction mode requests from the user side
	localparam logic [1:0] MODE_FORCED_CCM = 2'h0;
	localparam logic [1:0] MODE_DIODE_EMU = 2'h1;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h2;

	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_WAKE = 4'h2,
		ST_RUN = 4'h4,
		ST_PARK = 4'h8
	} tpg_state_type;

endpackage

// File: tpg_pwm_gen.sv
// Purpose: free-running pwm period and duty generator
// Assumes: period and on_time already clamped by the caller
// Notes: new settings take effect only at a period boundary
`timescale 1ns/1ps
`default_nettype none
module tpg_pwm_gen import tpg_pkg::*; #(
	parameter int WIDTH = PERIOD_WIDTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// control
	input wire logic run,
	input wire logic [WIDTH-1:0] period,
	input wire logic [WIDTH-1:0] on_time,
	// output
	output logic level
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic [WIDTH-1:0] cur_period;
	logic [WIDTH-1:0] next_cur_period;
	logic [WIDTH-1:0] cur_on;
	logic [WIDTH-1:0] next_cur_on;
	logic next_level;

	always_comb begin
		next_count = count;
		next_cur_period = cur_period;
		next_cur_on = cur_on;
		next_level = 1'b0;
		if (!run) begin
			// preload the last count so the first period after start is full length;
			// a short first period would switch faster than the legal limit
			next_count = period - WIDTH'(1);
			next_cur_period = period;
			next_cur_on = on_time;
		end else if (count >= cur_period - WIDTH'(1)) begin
			// glitch-free update: latch settings only between periods
			next_count = '0;
			next_cur_period = period;
			next_cur_on = on_time;
			next_level = on_time != '0;
		end else begin
			next_count = count + WIDTH'(1);
			next_level = (count + WIDTH'(1)) < cur_on;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
			cur_period <= '0;
			cur_on <= '0;
			level <= 1'b0;
		end else begin
			count <= next_count;
			cur_period <= next_cur_period;
			cur_on <= next_cur_on;
			level <= next_level;
		end
	end

endmodule
`default_nettype wire

// File: tpg_drv_model.sv
// Purpose: behavioural gate driver that answers the host pins
// Assumes: a released pin sits at its open or three-state level
// Notes: hold-off and wake time counted in clk cycles
`timescale 1ns/1ps
`default_nettype none
module tpg_drv_model #(
	parameter int HOLD_CYCLES = 35,
	parameter int WAKE_CYCLES = 10
) (
	// timing reference
	input wire logic clk,
	// supply and load
	input wire logic supply_ok,
	input wire logic current_positive,
	// pins from the host
	input wire logic pwm_out,
	input wire logic pwm_oe,
	input wire logic mode_out,
	input wire logic mode_oe,
	// gate commands
	output logic high_side_gate,
	output logic low_side_gate
);
	int tri_count = HOLD_CYCLES;
	int wake_count = 0;
	logic last_level = 1'b0;
	logic level;
	logic active;
	always @(posedge clk) begin
		wake_count <= (supply_ok && mode_oe) ? wake_count + 1 : 0;
		tri_count <= pwm_oe ? 0 : (tri_count < HOLD_CYCLES ? tri_count + 1 : tri_count);
		last_level <= level;
	end
	assign level = pwm_oe ? pwm_out : last_level;
	assign active = supply_ok && mode_oe && wake_count >= WAKE_CYCLES && tri_count < HOLD_CYCLES;
	assign high_side_gate = active && level;
	assign low_side_gate = active && !level && (mode_out || current_positive);
endmodule
`default_nettype wire

// File: tpg_host_tb_top.sv
// Purpose: self-checking bench of the gate-driver host controller
// Assumes: startup wait shortened to 20 cycles
// Notes: driver side is a behavioural model on the host pins
`timescale 1ns/1ps
`default_nettype none
module tpg_host_tb_top import tpg_pkg::*;;
	localparam int PU = 20;
	logic clk = 0, resetn = 0, enable = 0, phase_shed = 0, supply_ok = 0, cur_pos = 1;
	logic [1:0] mode_req = 2'h0;
	logic [15:0] period_req = 16'h000A, on_time_req = 16'h0005;
	logic pwm_out, pwm_oe, mode_out, mode_oe, ready, high_side_gate, low_side_gate;
	int mismatches = 0, samples_checked = 0;
	initial begin
		forever #2.5 clk = ~clk;
	end
	tpg_host #(.WIDTH(16), .POWERUP_CYCLES(PU)) u_dut (.clk(clk), .resetn(resetn),
		.enable(enable), .mode_req(mode_req), .phase_shed(phase_shed),
		.period_req(period_req), .on_time_req(on_time_req), .pwm_out(pwm_out),
		.pwm_oe(pwm_oe), .conduction_mode_select_out(mode_out),
		.conduction_mode_select_oe(mode_oe), .ready(ready));
	tpg_drv_model u_drv (.clk(clk), .supply_ok(supply_ok), .current_positive(cur_pos),
		.pwm_out(pwm_out), .pwm_oe(pwm_oe), .mode_out(mode_out), .mode_oe(mode_oe),
		.high_side_gate(high_side_gate), .low_side_gate(low_side_gate));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wait_pwm(input logic v, output int n);
		n = 0;
		while (pwm_out !== v && n < 300) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic t_wake;
		int n;
		n = 0;
		enable = 1'b1;
		mode_req = 2'h0;
		@(negedge clk);
		chk("mode_out", 1'b1, mode_out);
		while (pwm_oe !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk("wake cycles", 16'(PU), 16'(n));
		chk("ready", 1'b1, ready);
	endtask
	task automatic t_period;
		int h, l;
		wait_pwm(1'b0, l);
		wait_pwm(1'b1, l);
		chk("high gate", 1'b1, high_side_gate);
		wait_pwm(1'b0, h);
		chk("low gate", 1'b1, low_side_gate);
		wait_pwm(1'b1, l);
		chk("on time", 16'h0005, 16'(h));
		chk("period", 16'(MIN_PERIOD_CYCLES), 16'(h + l));
	endtask
	task automatic t_diode;
		int n;
		mode_req = 2'h1;
		cur_pos = 1'b0;
		@(negedge clk);
		chk("mode pins", 2'b01, {mode_out, mode_oe});
		wait_pwm(1'b0, n);
		chk("low gate reversed", 1'b0, low_side_gate);
		cur_pos = 1'b1;
		mode_req = 2'h3;
		#1;
		chk("low gate forward", 1'b1, low_side_gate);
		@(negedge clk);
		chk("spare mode pins", 2'b01, {mode_out, mode_oe});
		mode_req = 2'h0;
	endtask
	task automatic t_shed;
		phase_shed = 1'b1;
		@(negedge clk);
		chk("shed pins", 2'b01, {pwm_oe, ready});
		repeat (40) @(negedge clk);
		chk("shed gates", 2'b00, {high_side_gate, low_side_gate});
		phase_shed = 1'b0;
		@(negedge clk);
		chk("pwm_oe", 1'b1, pwm_oe);
	endtask
	task automatic t_off;
		mode_req = 2'h2;
		@(negedge clk);
		chk("off pins", 3'b000, {mode_oe, pwm_oe, ready});
		chk("off gates", 2'b00, {high_side_gate, low_side_gate});
	endtask
	task automatic final_report;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		chk("reset gates", 2'b00, {high_side_gate, low_side_gate});
		resetn = 1'b1;
		supply_ok = 1'b1;
		@(negedge clk);
		chk("reset pins", 3'b000, {mode_oe, pwm_oe, ready});
		t_wake;
		t_period;
		t_diode;
		t_shed;
		t_off;
		t_wake;
		t_period;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report;
	end
endmodule
`default_nettype wire
